// *** core/dbcc_defines.svh ***
// register addresses, field positions, reset values and timing for the buck config bank
`ifndef DBCC_DEFINES_SVH
`define DBCC_DEFINES_SVH
// ****************************************************************
// register addresses
// ****************************************************************
`define DBCC_ADDR_VOUT1 8'h23
`define DBCC_ADDR_CFG1_1 8'h25
`define DBCC_ADDR_CFG2_1 8'h26
`define DBCC_ADDR_CFG3_1 8'h27
`define DBCC_ADDR_VOUT2 8'h33
`define DBCC_ADDR_CFG1_2 8'h35
`define DBCC_ADDR_CFG2_2 8'h36
`define DBCC_ADDR_CFG3_2 8'h37
// slot of each register inside a channel set
`define DBCC_IX_VOUT 2'h0
`define DBCC_IX_CFG1 2'h1
`define DBCC_IX_CFG2 2'h2
`define DBCC_IX_CFG3 2'h3
// ****************************************************************
// reset values
// ****************************************************************
`define DBCC_RST_VOUT1 8'h41
`define DBCC_RST_VOUT2 8'h96
`define DBCC_RST_CFG1 8'h84
`define DBCC_RST_CFG2 8'h0E
`define DBCC_RST_CFG3 8'h87
// ****************************************************************
// field positions
// ****************************************************************
`define DBCC_F_RNG 7:6
`define DBCC_F_RD 5:3
`define DBCC_F_RU 2:0
`define DBCC_F_ENV 7:6
`define DBCC_F_SSF 5:4
`define DBCC_F_PAT 3:2
`define DBCC_B_FSREN 1
`define DBCC_B_FPWM 0
`define DBCC_B_DIS100 7
`define DBCC_B_DIS1 6
`define DBCC_B_ULTRA 5
`define DBCC_B_FTRAK 4
`define DBCC_F_FREQ 3:2
`define DBCC_F_ILIM 1:0
// ****************************************************************
// decode limits and timing
// ****************************************************************
`define DBCC_SAT_LOW 8'hA0
`define DBCC_SAT_MID 8'h8C
`define DBCC_SEQ_SEED 4'h1
`define DBCC_SEQ_TOP 4'hF
`define DBCC_DIS_TIME_US 1000
`define DBCC_CLK_MHZ 100
`endif

// *** core/dbcc_pkg.sv ***
// shared types of the buck channel config bank
`default_nettype none
package dbcc_pkg;
    typedef logic [7:0] dbcc_byte_t;
    typedef enum logic [1:0] {DBCC_PAT_TRI, DBCC_PAT_POLY_A, DBCC_PAT_POLY_B, DBCC_PAT_ALT} dbcc_pat_e;
    typedef enum logic [1:0] {DBCC_RNG_LOW, DBCC_RNG_MID, DBCC_RNG_HIGH, DBCC_RNG_RSVD} dbcc_rng_e;
    typedef struct packed {
        logic [3:0] tri_v;
        logic down;
        logic [3:0] lfsr;
        logic use_b;
        logic [3:0] value;
    } dbcc_seq_s;
endpackage : dbcc_pkg
`default_nettype wire

// *** core/dbcc_spread_seq.sv ***
// spread-spectrum pattern sequencer for one channel
`include "dbcc_defines.svh"
`default_nettype none
module dbcc_spread_seq
    import dbcc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [1:0] pattern,
    output logic [3:0] value
);
    dbcc_seq_s s_ff;
    dbcc_seq_s nxt_s;

    // ****************************************************************
    // step functions
    // ****************************************************************
    function automatic logic [3:0] dbcc_step_a(input logic [3:0] q);
        return {q[2:0], q[3] ^ q[0]}; // x^4+x+1
    endfunction : dbcc_step_a

    function automatic logic [3:0] dbcc_step_b(input logic [3:0] q);
        return {q[2:0], q[3] ^ q[2]}; // x^4+x^3+1
    endfunction : dbcc_step_b

    // next state; neither polynomial can reach all-zero from a nonzero seed
    always_comb begin
        nxt_s = s_ff;
        if (!run) begin
            nxt_s.tri_v = `DBCC_SEQ_SEED;
            nxt_s.down = 1'b0;
            nxt_s.lfsr = `DBCC_SEQ_SEED;
            nxt_s.use_b = 1'b0;
            nxt_s.value = '0;
        end else begin
            // triangle bounces between 0001b and 1111b
            if (!s_ff.down) begin
                if (s_ff.tri_v == `DBCC_SEQ_TOP) begin
                    nxt_s.down = 1'b1;
                    nxt_s.tri_v = s_ff.tri_v - 4'h1;
                end else begin
                    nxt_s.tri_v = s_ff.tri_v + 4'h1;
                end
            end else if (s_ff.tri_v == `DBCC_SEQ_SEED) begin
                nxt_s.down = 1'b0;
                nxt_s.tri_v = s_ff.tri_v + 4'h1;
            end else begin
                nxt_s.tri_v = s_ff.tri_v - 4'h1;
            end
            case (dbcc_pat_e'(pattern))
                DBCC_PAT_TRI: nxt_s.value = nxt_s.tri_v;
                DBCC_PAT_POLY_A: nxt_s.lfsr = dbcc_step_a(s_ff.lfsr);
                DBCC_PAT_POLY_B: nxt_s.lfsr = dbcc_step_b(s_ff.lfsr);
                default: begin
                    nxt_s.lfsr = s_ff.use_b ? dbcc_step_b(s_ff.lfsr) : dbcc_step_a(s_ff.lfsr);
                    nxt_s.use_b = !s_ff.use_b;
                end
            endcase
            if (dbcc_pat_e'(pattern) != DBCC_PAT_TRI) begin
                nxt_s.value = nxt_s.lfsr;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign value = s_ff.value;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_seq_nonzero: assert property (@(posedge clk) disable iff (!resetn)
        run |=> value != 4'h0)
        else $error("sequencer produced zero while running");
    chk_tri_step: assert property (@(posedge clk) disable iff (!resetn)
        (run && pattern == DBCC_PAT_TRI) [*3] |->
        (value == $past(value) + 4'h1) || (value == $past(value) - 4'h1))
        else $error("triangle moved by other than one");
endmodule : dbcc_spread_seq
`default_nettype wire

// *** core/dbcc_regs.sv ***
// two-channel buck configuration register bank with decoded settings
`include "dbcc_defines.svh"
`default_nettype none
module dbcc_regs
    import dbcc_pkg::*;
#(
    parameter int DIS_CYCLES = `DBCC_DIS_TIME_US * `DBCC_CLK_MHZ,
    parameter int DTW = 17
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] ch_enabled,
    input wire logic ch1_forced_pulse_width_pin_n,
    input wire logic ch2_forced_pulse_width_pin_n,
    input wire logic [1:0] target_below_actual,
    input wire logic [1:0] soft_stop_done,
    output logic [1:0][12:0] target_mv,
    output logic [1:0] range_reserved,
    output logic [1:0][15:0] ramp_up_rate,
    output logic [1:0][16:0] ramp_down_rate,
    output logic [1:0][4:0] spread_pct,
    output logic [1:0][2:0] spread_khz,
    output logic [1:0][3:0] spread_step,
    output logic [1:0] fpwm_active,
    output logic [1:0] sink_enable,
    output logic [1:0] ultrasonic_on,
    output logic [1:0] freq_tracking_on,
    output logic [1:0] discharge_100ohm_on,
    output logic [1:0] discharge_1ohm_active,
    output logic [1:0][10:0] switching_khz,
    output logic [1:0][12:0] peak_limit_ma
);
    // refuse a discharge window that the timer cannot count
    if (DIS_CYCLES < 1 || DIS_CYCLES >= (1 << DTW)) begin : g_bad_dis
        $error("discharge count does not fit its counter");
    end

    typedef struct packed {
        logic [1:0][3:0][7:0] regs;
        logic [1:0][DTW-1:0] tmr;
        logic [7:0] rdata;
        logic [1:0][12:0] tgt;
        logic [1:0] rsv;
        logic [1:0][15:0] up;
        logic [1:0][16:0] dn;
        logic [1:0][4:0] pct;
        logic [1:0][2:0] khz;
        logic [1:0][4:0] flg;
        logic [1:0][10:0] fsw;
        logic [1:0][12:0] ilim;
    } dbcc_main_s;

    dbcc_main_s s_ff;
    dbcc_main_s nxt_s;
    logic [1:0] pin_on;

    // ****************************************************************
    // decode functions
    // ****************************************************************
    function automatic logic [3:0] dbcc_decode(input logic [7:0] a);
        if (a == `DBCC_ADDR_VOUT1) return {2'b10, `DBCC_IX_VOUT};
        else if (a == `DBCC_ADDR_CFG1_1) return {2'b10, `DBCC_IX_CFG1};
        else if (a == `DBCC_ADDR_CFG2_1) return {2'b10, `DBCC_IX_CFG2};
        else if (a == `DBCC_ADDR_CFG3_1) return {2'b10, `DBCC_IX_CFG3};
        else if (a == `DBCC_ADDR_VOUT2) return {2'b11, `DBCC_IX_VOUT};
        else if (a == `DBCC_ADDR_CFG1_2) return {2'b11, `DBCC_IX_CFG1};
        else if (a == `DBCC_ADDR_CFG2_2) return {2'b11, `DBCC_IX_CFG2};
        else if (a == `DBCC_ADDR_CFG3_2) return {2'b11, `DBCC_IX_CFG3};
        else return 4'h0;
    endfunction : dbcc_decode

    // millivolts from range and code
    function automatic logic [12:0] dbcc_vout_mv(input logic [1:0] rng, input logic [7:0] c);
        case (dbcc_rng_e'(rng))
            DBCC_RNG_LOW: return (c >= `DBCC_SAT_MID) ? 13'h04B0 : 13'h01F4 + 13'(c) * 13'h0005;
            DBCC_RNG_MID: return (c >= `DBCC_SAT_MID) ? 13'h0960 : 13'h03E8 + 13'(c) * 13'h000A;
            DBCC_RNG_HIGH: return (c >= `DBCC_SAT_LOW) ? 13'h1450 : 13'h07D0 + 13'(c) * 13'h0014;
            default: return 13'h0000; // reserved range drives nothing
        endcase
    endfunction : dbcc_vout_mv

    // slew magnitude in uV/us
    function automatic logic [15:0] dbcc_slew_uv(input logic [2:0] c);
        case (c)
            3'h0: return 16'h0096;
            3'h1: return 16'h0271;
            3'h2: return 16'h04E2;
            3'h3: return 16'h09C4;
            3'h4: return 16'h1388;
            3'h5: return 16'h2710;
            3'h6: return 16'h4E20;
            default: return 16'h9C40;
        endcase
    endfunction : dbcc_slew_uv

    assign pin_on = {!ch2_forced_pulse_width_pin_n, !ch1_forced_pulse_width_pin_n};

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [3:0] sel;
        logic [7:0] wv;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        sel = dbcc_decode(reg_addr);
        wv = reg_wdata;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        nxt_s = s_ff;
        // registered read, no side effects
        if (reg_rd_en) begin
            nxt_s.rdata = sel[3] ? s_ff.regs[sel[2]][sel[1:0]] : 8'h00;
        end
        // writes; range is frozen while the output runs
        if (reg_wr_en && sel[3]) begin
            if (sel[1:0] == `DBCC_IX_CFG1 && ch_enabled[sel[2]]) begin
                wv[`DBCC_F_RNG] = s_ff.regs[sel[2]][`DBCC_IX_CFG1][`DBCC_F_RNG];
            end
            nxt_s.regs[sel[2]][sel[1:0]] = wv;
        end
        for (int ch = 0; ch < 2; ch++) begin
            c1 = s_ff.regs[ch][`DBCC_IX_CFG1];
            c2 = s_ff.regs[ch][`DBCC_IX_CFG2];
            c3 = s_ff.regs[ch][`DBCC_IX_CFG3];
            nxt_s.tgt[ch] = dbcc_vout_mv(c1[`DBCC_F_RNG], s_ff.regs[ch][`DBCC_IX_VOUT]);
            nxt_s.rsv[ch] = c1[`DBCC_F_RNG] == DBCC_RNG_RSVD;
            nxt_s.up[ch] = dbcc_slew_uv(c1[`DBCC_F_RU]);
            nxt_s.dn[ch] = 17'(-{1'b0, dbcc_slew_uv(c1[`DBCC_F_RD])});
            // envelope steps of four percent from eight percent up; code zero is off
            nxt_s.pct[ch] = (c2[`DBCC_F_ENV] == 2'h0) ? 5'h00 : 5'h04 + 5'(c2[`DBCC_F_ENV]) * 5'h04;
            nxt_s.khz[ch] = {c2[`DBCC_F_SSF], 1'b1};
            // forced pwm from bit or pin, plus sinking when falling slew is on
            nxt_s.flg[ch][0] = c2[`DBCC_B_FPWM] | pin_on[ch]
                | (c2[`DBCC_B_FSREN] & target_below_actual[ch]);
            nxt_s.flg[ch][1] = c2[`DBCC_B_FSREN] & target_below_actual[ch];
            nxt_s.flg[ch][2] = c3[`DBCC_B_ULTRA];
            nxt_s.flg[ch][3] = c3[`DBCC_B_FTRAK];
            nxt_s.flg[ch][4] = c3[`DBCC_B_DIS100];
            case (c3[`DBCC_F_FREQ]) // codes 2 and 3 share 1.6 MHz
                2'h0: nxt_s.fsw[ch] = 11'h1F4;
                2'h1: nxt_s.fsw[ch] = 11'h3E8;
                default: nxt_s.fsw[ch] = 11'h640;
            endcase
            case (c3[`DBCC_F_ILIM])
                2'h0: nxt_s.ilim[ch] = 13'h05DC;
                2'h1: nxt_s.ilim[ch] = 13'h08CA;
                2'h2: nxt_s.ilim[ch] = 13'h0BB8;
                default: nxt_s.ilim[ch] = 13'h1194;
            endcase
            // low-impedance discharge window after soft-stop
            if (soft_stop_done[ch] && c3[`DBCC_B_DIS1]) begin
                nxt_s.tmr[ch] = DTW'(DIS_CYCLES);
            end else if (s_ff.tmr[ch] != '0) begin
                nxt_s.tmr[ch] = s_ff.tmr[ch] - DTW'(1);
            end
        end
    end

    // state register; reset values of each channel set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
            s_ff.regs <= {`DBCC_RST_CFG3, `DBCC_RST_CFG2, `DBCC_RST_CFG1, `DBCC_RST_VOUT2,
                          `DBCC_RST_CFG3, `DBCC_RST_CFG2, `DBCC_RST_CFG1, `DBCC_RST_VOUT1};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // outputs and sequencers
    // ****************************************************************
    assign reg_rdata = s_ff.rdata;
    assign target_mv = s_ff.tgt;
    assign range_reserved = s_ff.rsv;
    assign ramp_up_rate = s_ff.up;
    assign ramp_down_rate = s_ff.dn;
    assign spread_pct = s_ff.pct;
    assign spread_khz = s_ff.khz;
    assign switching_khz = s_ff.fsw;
    assign peak_limit_ma = s_ff.ilim;
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign fpwm_active[g] = s_ff.flg[g][0];
        assign sink_enable[g] = s_ff.flg[g][1];
        assign ultrasonic_on[g] = s_ff.flg[g][2];
        assign freq_tracking_on[g] = s_ff.flg[g][3];
        assign discharge_100ohm_on[g] = s_ff.flg[g][4];
        assign discharge_1ohm_active[g] = s_ff.tmr[g] != '0;
        // sequencer runs only while the envelope is nonzero
        dbcc_spread_seq u_seq (
            .clk(clk),
            .resetn(resetn),
            .run(s_ff.regs[g][`DBCC_IX_CFG2][`DBCC_F_ENV] != 2'h0),
            .pattern(s_ff.regs[g][`DBCC_IX_CFG2][`DBCC_F_PAT]),
            .value(spread_step[g])
        );
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_write_cfg1_ch2;
        reg_wr_en && reg_addr == `DBCC_ADDR_CFG1_2;
    endsequence
    sequence s_read_back;
        reg_rd_en && !reg_wr_en ##1 1'b1;
    endsequence

    chk_range_hold: assert property (s_write_cfg1_ch2 and ch_enabled[1] |=>
        s_ff.regs[1][`DBCC_IX_CFG1][`DBCC_F_RNG] == $past(s_ff.regs[1][`DBCC_IX_CFG1][`DBCC_F_RNG]))
        else $error("range changed while output enabled");
    chk_vout_sat: assert property (s_ff.regs[1][`DBCC_IX_CFG1][`DBCC_F_RNG] == 2'h2
        && s_ff.regs[1][`DBCC_IX_VOUT] >= `DBCC_SAT_LOW |=> target_mv[1] == 13'h1450)
        else $error("high range did not saturate at 5.20 V");
    chk_slew_top: assert property (s_ff.regs[1][`DBCC_IX_CFG1][`DBCC_F_RU] == 3'h7
        |=> ramp_up_rate[1] == 16'h9C40)
        else $error("fastest ramp code not 40 mV/us");
    chk_spread_off: assert property (s_ff.regs[0][`DBCC_IX_CFG2][`DBCC_F_ENV] == 2'h0
        |=> spread_pct[0] == 5'h00 && spread_step[0] == 4'h0)
        else $error("spread active with envelope off");
    chk_no_sink: assert property (!s_ff.regs[1][`DBCC_IX_CFG2][`DBCC_B_FSREN]
        |=> !sink_enable[1])
        else $error("sinking with falling slew disabled");
    chk_fpwm_pin: assert property (!ch1_forced_pulse_width_pin_n |=> fpwm_active[0])
        else $error("forced pwm pin ignored");
    chk_dis_start: assert property (soft_stop_done[0]
        && s_ff.regs[0][`DBCC_IX_CFG3][`DBCC_B_DIS1] |=> discharge_1ohm_active[0])
        else $error("1-ohm discharge did not start");
    chk_dis_idle: assert property (!discharge_1ohm_active[0]
        && !(soft_stop_done[0] && s_ff.regs[0][`DBCC_IX_CFG3][`DBCC_B_DIS1])
        |=> !discharge_1ohm_active[0])
        else $error("1-ohm discharge started without soft-stop");
    chk_ultra_map: assert property (##1 ultrasonic_on[1] ==
        $past(s_ff.regs[1][`DBCC_IX_CFG3][`DBCC_B_ULTRA]))
        else $error("ultrasonic output does not follow its bit");
    chk_freq_fold: assert property (s_ff.regs[1][`DBCC_IX_CFG3][`DBCC_F_FREQ] >= 2'h2
        |=> switching_khz[1] == 11'h640)
        else $error("codes 2 and 3 not 1.6 MHz");
    chk_ilim_top: assert property (s_ff.regs[0][`DBCC_IX_CFG3][`DBCC_F_ILIM] == 2'h3
        |=> peak_limit_ma[0] == 13'h1194)
        else $error("current limit code 3 not 4.50 A");
    chk_read_back: assert property (reg_rd_en && !reg_wr_en
        && reg_addr == `DBCC_ADDR_VOUT2 |=> reg_rdata == $past(s_ff.regs[1][`DBCC_IX_VOUT]))
        else $error("read value differs from stored value");
    chk_read_pure: assert property (s_read_back |-> s_ff.regs == $past(s_ff.regs))
        else $error("read disturbed a register");
endmodule : dbcc_regs
`default_nettype wire

// *** verif/dbcc_host_model.sv ***
// host model: drives the config bank's write and read strobes
`default_nettype none
module dbcc_host_model (
    input wire logic clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // bus idle state
    // ****************************************************************
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one strobe per write; data inverted after it so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // read strobe; answer taken one cycle after the edge that took it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : dbcc_host_model
`default_nettype wire

// *** verif/dbcc_regs_bench.sv ***
// self-checking bench for the two-channel buck config bank
`default_nettype none
module dbcc_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] ch_en = 2'b00, tba = 2'b00, ssd = 2'b00;
    logic pin1_n = 1'b1, pin2_n = 1'b1;
    logic wr_en, rd_en;
    logic [7:0] addr, wdata, rdata;
    logic [1:0][12:0] target_mv, peak_limit_ma;
    logic [1:0][15:0] ramp_up_rate;
    logic [1:0][16:0] ramp_down_rate;
    logic [1:0][4:0] spread_pct;
    logic [1:0][2:0] spread_khz;
    logic [1:0][3:0] spread_step;
    logic [1:0][10:0] switching_khz;
    logic [1:0] range_reserved, fpwm_active, sink_enable, ultrasonic_on, ftrak_on, dis100, dis1;
    int miscompares = 0;
    int check_count = 0;
    int n;
    // short discharge window keeps the run brief
    localparam int DIS = 20;
    localparam int RU[8] = '{150, 625, 1250, 2500, 5000, 10000, 20000, 40000};
    localparam int FK[4] = '{500, 1000, 1600, 1600};
    localparam int IL[4] = '{1500, 2250, 3000, 4500};
    localparam int PC[4] = '{0, 8, 12, 16};
    localparam int KZ[4] = '{1, 3, 5, 7};
    localparam logic [7:0] RA[8] = '{8'h23, 8'h25, 8'h26, 8'h27, 8'h33, 8'h35, 8'h36, 8'h37};
    localparam logic [7:0] RV[8] = '{8'h41, 8'h84, 8'h0E, 8'h87, 8'h96, 8'h84, 8'h0E, 8'h87};
    localparam logic [1:0] VR[5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
    localparam logic [7:0] VC[5] = '{8'h10, 8'h8C, 8'h8B, 8'h9F, 8'hA0};
    localparam int VM[5] = '{580, 1200, 2390, 5180, 5200};
    always #5 clk = ~clk;
    dbcc_host_model dbcc_host_model_i (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
    dbcc_regs #(.DIS_CYCLES(DIS)) dbcc_regs_i (.clk(clk), .resetn(resetn), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .ch_enabled(ch_en), .ch1_forced_pulse_width_pin_n(pin1_n),
        .ch2_forced_pulse_width_pin_n(pin2_n), .target_below_actual(tba), .soft_stop_done(ssd),
        .target_mv(target_mv), .range_reserved(range_reserved), .ramp_up_rate(ramp_up_rate),
        .ramp_down_rate(ramp_down_rate), .spread_pct(spread_pct), .spread_khz(spread_khz),
        .spread_step(spread_step), .fpwm_active(fpwm_active), .sink_enable(sink_enable),
        .ultrasonic_on(ultrasonic_on), .freq_tracking_on(ftrak_on),
        .discharge_100ohm_on(dis100), .discharge_1ohm_active(dis1),
        .switching_khz(switching_khz), .peak_limit_ma(peak_limit_ma));
    // ****************************************************************
    // compare, access and verdict tasks
    // ****************************************************************
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        dbcc_host_model_i.rd(a, d);
        chk({9'h000, d}, {9'h000, exp});
    endtask : rchk
    // decoded outputs follow a write one edge after the edge that stores it
    task automatic wset(input logic [7:0] a, input logic [7:0] d);
        dbcc_host_model_i.wr(a, d);
        repeat (2) @(posedge clk);
        #1;
    endtask : wset
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 8; i++) rchk(RA[i], RV[i]);
        rchk(8'h30, 8'h00);
        chk(17'(switching_khz[0]), 17'h003E8);
        chk(17'(peak_limit_ma[0]), 17'h01194);
        chk({11'h0, dis100, dis1, ultrasonic_on}, 17'h30);
        $display("test reset_values done");
        for (int c = 0; c < 8; c++) begin
            wset(8'h35, {2'b10, 3'(c), 3'(c)});
            chk(17'(ramp_up_rate[1]), 17'(RU[c]));
            chk(ramp_down_rate[1], -17'(RU[c]));
        end
        for (int c = 0; c < 4; c++) begin
            wset(8'h37, {2'b00, 2'(c), 2'(c), 2'(c)});
            chk(17'(switching_khz[1]), 17'(FK[c]));
            chk(17'(peak_limit_ma[1]), 17'(IL[c]));
            chk({14'h0, dis100[1], ultrasonic_on[1], ftrak_on[1]}, 17'(c));
            wset(8'h36, {2'(c), 2'(c), 4'hE});
            chk(17'(spread_pct[1]), 17'(PC[c]));
            chk(17'(spread_khz[1]), 17'(KZ[c]));
        end
        $display("test field_decode done");
        for (int i = 0; i < 5; i++) begin
            wset(8'h35, {VR[i], 6'h04});
            wset(8'h33, VC[i]);
            chk(17'(target_mv[1]), 17'(VM[i]));
        end
        wset(8'h35, 8'hC4);
        chk({15'h0, range_reserved}, 17'h2);
        @(posedge clk);
        ch_en <= 2'b10;
        wset(8'h35, 8'h3F);
        rchk(8'h35, 8'hFF);
        rchk(8'h25, 8'h84);
        @(posedge clk);
        ch_en <= 2'b00;
        $display("test voltage_range done");
        chk(17'(fpwm_active[0]), 17'h0);
        @(posedge clk);
        pin1_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(17'(fpwm_active[0]), 17'h1);
        @(posedge clk);
        pin1_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(17'(fpwm_active[0]), 17'h0);
        wset(8'h26, 8'h0F);
        chk(17'(fpwm_active[0]), 17'h1);
        wset(8'h36, 8'h0E);
        @(posedge clk);
        tba <= 2'b10;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, sink_enable[1], fpwm_active[1]}, 17'h3);
        wset(8'h36, 8'h0C);
        chk(17'(sink_enable[1]), 17'h0);
        @(posedge clk);
        tba <= 2'b00;
        $display("test pwm_sink done");
        wset(8'h27, 8'hC7);
        @(posedge clk);
        ssd <= 2'b01;
        @(posedge clk);
        ssd <= 2'b00;
        #1;
        n = 0;
        for (int i = 0; i < 2 * DIS; i++) begin
            if (dis1[0] === 1'b1) n++;
            @(posedge clk);
            #1;
        end
        chk(17'(n), 17'(DIS));
        $display("test discharge done");
        for (int p = 0; p < 4; p++) begin
            wset(8'h26, {4'h4, 2'(p), 2'b10});
            for (int i = 0; i < 16; i++) begin
                chk(17'(spread_step[0] != 4'h0), 17'h1);
                @(posedge clk);
                #1;
            end
        end
        wset(8'h26, 8'h0E);
        chk(17'(spread_step[0]), 17'h0);
        $display("test spread_seq done");
        print_verdict();
    end
endmodule : dbcc_regs_bench
`default_nettype wire
